// ===== pkg/pel_cfg.svh
// Constants for the peripheral event linker.
`ifndef PEL_CFG_SVH
`define PEL_CFG_SVH
`define PEL_NUM_SRC 18
`define PEL_NUM_DST 6
`define PEL_SEL_BASE 20'hF0300
`define PEL_SEL_LAST 20'hF0311
`define PEL_SEL_RESET 8'h00
`define PEL_DEST_LSB 0
`define PEL_DEST_MSB 2
`define PEL_DST_ADC 3'h1
`define PEL_DST_TA_CH0 3'h2
`define PEL_DST_TA_CH1 3'h3
`define PEL_DST_ITMR 3'h4
`define PEL_DST_ADV0 3'h5
`define PEL_DST_ADV1 3'h6
`endif

// ===== pkg/pel_pkg.sv
// Types for the peripheral event linker.
package pel_pkg;
  typedef logic [2:0] pel_dest_t;
  typedef logic [19:0] pel_addr_t;
  typedef logic [7:0] pel_data_t;
endpackage

// ===== pkg/pel_if.sv
// Event link between the linker and the peripheral side.
`timescale 1ns/100ps
interface pel_if;
  // Source events, one-cycle pulses.
  logic [17:0] src_event;
  // Destination events.
  logic adc_trigger;
  logic ta_ch0_input;
  logic ta_ch1_input;
  logic itmr_count_src;
  logic adv0_capture_d;
  logic adv1_capture_d;
  logic adv0_cutoff;
  logic adv1_cutoff;
  modport linker (input src_event, output adc_trigger, ta_ch0_input, ta_ch1_input, itmr_count_src,
    adv0_capture_d, adv1_capture_d, adv0_cutoff, adv1_cutoff);
  modport periph (output src_event, input adc_trigger, ta_ch0_input, ta_ch1_input, itmr_count_src,
    adv0_capture_d, adv1_capture_d, adv0_cutoff, adv1_cutoff);
endinterface

// ===== hw/pel_linker.sv
// Peripheral event linker: selector registers and event routing.
// Notes
// A source pulse on the link reaches its destination output one clock later,
// and every destination output is a flop, so receivers see clean pulses.
// Selectors should change only while the sources are idle: a write that lands
// beside a pulse can steer that pulse to the old or to the new destination.
// Code seven is stored and reads back, but it routes nowhere.
// Two sources sharing one destination are merged by OR; receivers cannot
// tell them apart, which is why software keeps destinations distinct.
// Clock enable low freezes the selectors, the read data and the pulses alike.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "pel_cfg.svh"
module pel_linker
  import pel_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Event link.
  pel_if.linker link
);
  typedef struct packed {
    logic [`PEL_NUM_SRC-1:0][2:0] sel;
    logic [7:0] rdata;
    logic [`PEL_NUM_DST-1:0] dst;
  } pel_state_t;

  pel_state_t st_r;
  pel_state_t st_nxt;

  // True when an address falls inside the selector window.
  function automatic logic sel_hit(input logic [19:0] a);
    sel_hit = (a >= `PEL_SEL_BASE) && (a <= `PEL_SEL_LAST);
  endfunction

  // Selector index of an address; only meaningful inside the window.
  function automatic logic [4:0] sel_index(input logic [19:0] a);
    logic [19:0] d;
    d = a - `PEL_SEL_BASE;
    sel_index = d[4:0];
  endfunction

  // One-hot destination vector of a selector code; zero and the reserved code route nowhere.
  function automatic logic [5:0] dest_decode(input pel_dest_t code);
    logic [5:0] v;
    v = 6'h00;
    case (code)
      // Conversion start trigger.
      `PEL_DST_ADC: begin
        v = 6'h01;
      end
      // Timer array channel 0 input.
      `PEL_DST_TA_CH0: begin
        v = 6'h02;
      end
      // Timer array channel 1 input.
      `PEL_DST_TA_CH1: begin
        v = 6'h04;
      end
      // Interval timer count source.
      `PEL_DST_ITMR: begin
        v = 6'h08;
      end
      // Advanced timer 0 capture and cutoff.
      `PEL_DST_ADV0: begin
        v = 6'h10;
      end
      // Advanced timer 1 capture and cutoff.
      `PEL_DST_ADV1: begin
        v = 6'h20;
      end
      default: begin
        v = 6'h00;
      end
    endcase
    dest_decode = v;
  endfunction

  // Register port decode.
  logic wr_hit;
  logic rd_hit;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic [7:0] rd_word;
  wire logic [`PEL_NUM_SRC-1:0] sel_we;
  wire logic [`PEL_NUM_DST-1:0] route [`PEL_NUM_SRC];
  wire logic [`PEL_NUM_DST-1:0] hit;

  // Write path: accesses outside the window are ignored.
  assign wr_hit = wr_i & sel_hit(addr_i);
  assign wr_idx = sel_index(addr_i);

  // Read path: a read outside the window returns zero.
  assign rd_hit = rd_i & sel_hit(addr_i);
  assign rd_idx = sel_index(addr_i);

  // Only three code bits are stored, so bits 7 to 3 always read back as zero.
  always_comb begin
    rd_word = 8'h00;
    for (int s = 0; s < `PEL_NUM_SRC; s++) begin
      if (rd_hit && rd_idx == 5'(s)) begin
        rd_word = {5'h00, st_r.sel[s]};
      end
    end
  end

  // Source order on the link:
  // 0-5 external pin edge events, 6 key return, 7 real-time clock,
  // 8-9 advanced timer 0 A and B, 10-11 advanced timer 1 A and B,
  // 12 advanced timer 1 underflow, 13 interval timer,
  // 14-17 timer array channels 0 to 3.
  genvar gs;
  genvar gd;
  generate
    for (gs = 0; gs < `PEL_NUM_SRC; gs++) begin : g_src
      // Write enable of this source's selector.
      assign sel_we[gs] = wr_hit & (wr_idx == 5'(gs));
      // A pulse lights exactly the destination its selector names, or none at all.
      assign route[gs] = link.src_event[gs] ? dest_decode(st_r.sel[gs]) : 6'h00;
    end

    for (gd = 0; gd < `PEL_NUM_DST; gd++) begin : g_dst
      logic any;
      // Sources mapped to one destination are merged rather than dropped.
      always_comb begin
        any = 1'b0;
        for (int s = 0; s < `PEL_NUM_SRC; s++) begin
          any = any | route[s][gd];
        end
      end
      assign hit[gd] = any;
    end
  endgenerate

  // Next state: destination pulses follow the source pulses by one cycle.
  always_comb begin
    st_nxt = st_r;
    st_nxt.dst = hit;
    st_nxt.rdata = rd_word;
    for (int s = 0; s < `PEL_NUM_SRC; s++) begin
      if (sel_we[s]) begin
        st_nxt.sel[s] = wdata_i[`PEL_DEST_MSB:`PEL_DEST_LSB];
      end
    end
  end

  // Selectors clear to zero, which routes every source nowhere.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Read data stand for the one cycle after the read strobe.
  assign rdata_o = st_r.rdata;

  // Conversion start trigger.
  assign link.adc_trigger = st_r.dst[0];

  // Timer array channel 0 input.
  assign link.ta_ch0_input = st_r.dst[1];

  // Timer array channel 1 input.
  assign link.ta_ch1_input = st_r.dst[2];

  // Interval timer count source.
  assign link.itmr_count_src = st_r.dst[3];

  // Advanced timer 0 raises capture and cutoff together.
  assign link.adv0_capture_d = st_r.dst[4];
  assign link.adv0_cutoff = st_r.dst[4];

  // Advanced timer 1 raises capture and cutoff together.
  assign link.adv1_capture_d = st_r.dst[5];
  assign link.adv1_cutoff = st_r.dst[5];
endmodule // pel_linker

// ===== hw/pel_periph.sv
// Peripheral side: drives source events and registers received destination events.
`timescale 1ns/100ps
`include "pel_cfg.svh"
module pel_periph
  import pel_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // User side.
  input wire logic [17:0] event_i,
  output logic [5:0] dest_o,
  output logic [1:0] cutoff_o,
  // Event link.
  pel_if.periph link
);
  typedef struct packed {
    logic [17:0] ev;
    logic [5:0] dest;
    logic [1:0] cut;
  } pel_pst_t;

  pel_pst_t st_r;
  pel_pst_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ev = event_i;
    st_nxt.dest = {link.adv1_capture_d, link.adv0_capture_d, link.itmr_count_src,
      link.ta_ch1_input, link.ta_ch0_input, link.adc_trigger};
    st_nxt.cut = {link.adv1_cutoff, link.adv0_cutoff};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Events are presented as registered one-cycle pulses; selectors are kept static by software.
  assign link.src_event = st_r.ev;
  assign dest_o = st_r.dest;
  assign cutoff_o = st_r.cut;
endmodule // pel_periph

// ===== verification/pel_link_chk.sv
// Checker for the event link between the linker and the peripheral side.
`timescale 1ns/100ps
module pel_link_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Event link.
  input wire logic [17:0] src_event,
  input wire logic adc_trigger,
  input wire logic ta_ch0_input,
  input wire logic ta_ch1_input,
  input wire logic itmr_count_src,
  input wire logic adv0_capture_d,
  input wire logic adv1_capture_d,
  input wire logic adv0_cutoff,
  input wire logic adv1_cutoff
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_adc_cause: assert property (adc_trigger |-> $past(|src_event)) else $error("stray adc");
  a_ch0_cause: assert property (ta_ch0_input |-> $past(|src_event)) else $error("stray ch0");
  a_ch1_cause: assert property (ta_ch1_input |-> $past(|src_event)) else $error("stray ch1");
  a_itmr_cause: assert property (itmr_count_src |-> $past(|src_event)) else $error("stray itmr");
  a_adv0_cause: assert property (adv0_capture_d |-> $past(|src_event)) else $error("stray adv0");
  a_adv1_cause: assert property (adv1_capture_d |-> $past(|src_event)) else $error("stray adv1");
  a_cut0_pair: assert property (adv0_cutoff == adv0_capture_d) else $error("cutoff0 split");
  a_cut1_pair: assert property (adv1_cutoff == adv1_capture_d) else $error("cutoff1 split");
  a_one_dest: assert property ($onehot0($past(src_event)) |-> $onehot0({adc_trigger, ta_ch0_input, ta_ch1_input,
    itmr_count_src, adv0_capture_d, adv1_capture_d})) else $error("event fanned out");
  c_adc: cover property (adc_trigger);
  c_itmr: cover property (itmr_count_src);
  c_cut1: cover property (adv1_cutoff);
endmodule // pel_link_chk

// ===== verification/tb_top.sv
// Testbench for the event linker and its peripheral side.
`timescale 1ns/100ps
module tb_top;
  import pel_pkg::*;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, ce = 1;
  pel_addr_t addr = 20'h00000;
  pel_data_t wdata = 8'h00;
  logic [17:0] ev = 18'h00000;
  logic [7:0] rdata;
  logic [5:0] dest;
  logic [1:0] cut;
  int mismatches = 0, cmp_count = 0;
  pel_if lk();
  pel_linker u_pel_linker (.clk_i, .rst_i, .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .link(lk));
  pel_periph u_pel_periph (.clk_i, .rst_i, .ce_i(ce), .event_i(ev), .dest_o(dest), .cutoff_o(cut), .link(lk));
  pel_link_chk u_pel_link_chk (.clk_i, .rst_i, .src_event(lk.src_event), .adc_trigger(lk.adc_trigger),
    .ta_ch0_input(lk.ta_ch0_input), .ta_ch1_input(lk.ta_ch1_input), .itmr_count_src(lk.itmr_count_src),
    .adv0_capture_d(lk.adv0_capture_d), .adv1_capture_d(lk.adv1_capture_d), .adv0_cutoff(lk.adv0_cutoff),
    .adv1_cutoff(lk.adv1_cutoff));
  always #4 clk_i = ~clk_i;
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr_reg(input pel_addr_t a, input pel_data_t d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input pel_addr_t a, input pel_data_t e, input string n);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, e, n);
  endtask
  // One-cycle source pulse, then wait until it has reached the user side.
  task pulse(input int s);
    @(posedge clk_i);
    ev <= 18'h00001 << s;
    @(posedge clk_i);
    ev <= 18'h00000;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    pel_dest_t d;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(20'hF0300, 8'h00, "sel00 reset");
    rd_reg(20'hF0311, 8'h00, "sel17 reset");
    wr_reg(20'hF0311, 8'hFE);
    rd_reg(20'hF0311, 8'h06, "sel17 high bits");
    wr_reg(20'hF0311, 8'h00);
    // A write while the clock enable is low must leave the selector untouched.
    ce <= 1'b0;
    wr_reg(20'hF0300, 8'h01);
    ce <= 1'b1;
    rd_reg(20'hF0300, 8'h00, "frozen write");
    wr_reg(20'hF0312, 8'h03);
    rd_reg(20'hF0312, 8'h00, "unmapped");
    // Every source, cycling through all six destinations.
    // One destination at a time, never the source's own function, written while idle.
    for (int s = 0; s < 18; s++) begin
      d = 3'((s + 3) % 6 + 1);
      wr_reg(20'hF0300 + 20'(s), {5'h00, d});
      pulse(s);
      chk({2'h0, dest}, 8'(6'h01 << (d - 3'h1)), "dest");
      chk({6'h00, cut}, {6'h00, d == 3'h6, d == 3'h5}, "cutoff");
      wr_reg(20'hF0300 + 20'(s), 8'h00);
      pulse(s);
      chk({2'h0, dest}, 8'h00, "disabled");
    end
    test_done;
  end
endmodule // tb_top
